// [common/cls_pkg.sv]
package cls_pkg;

	// System clock rate.
	localparam int CLS_CLK_MHZ = 100;

	// Link supervision timing.
	localparam int CLS_TWD_SHORT_MS = 32;
	localparam int CLS_TWD_LONG_MS  = 128;
	localparam int CLS_TWD_SHORT_CYC = CLS_TWD_SHORT_MS * 1000 * CLS_CLK_MHZ;
	localparam int CLS_TWD_LONG_CYC  = CLS_TWD_LONG_MS * 1000 * CLS_CLK_MHZ;

	// Input filter times.
	localparam int CLS_TDGL_IN_US  = 200;
	localparam int CLS_TDGL_RST_US = 10;
	localparam int CLS_TDGL_CLK_US = 2;
	localparam int CLS_TDGL_IN_CYC  = CLS_TDGL_IN_US * CLS_CLK_MHZ;
	localparam int CLS_TDGL_RST_CYC = CLS_TDGL_RST_US * CLS_CLK_MHZ;
	localparam int CLS_TDGL_CLK_CYC = CLS_TDGL_CLK_US * CLS_CLK_MHZ;

	// Reference clock low frequency limit, as the longest period allowed.
	localparam int CLS_FCLK_LOW_HZ = 100;
	localparam int CLS_CLK_LOW_CYC = (CLS_CLK_MHZ * 1000000) / CLS_FCLK_LOW_HZ;

	// Counter widths and channel count.
	localparam int CLS_WD_W   = 24;
	localparam int CLS_DGL_W  = 16;
	localparam int CLS_MON_W  = 20;
	localparam int CLS_BITC_W = 4;
	localparam int CLS_NCH    = 4;

	// Frame layout: position of the toggle bit within each 16-bit word.
	localparam int CLS_WORD_BITS = 16;
	localparam logic [3:0] CLS_TOGGLE_POS = 4'hF;

	// Values after reset.
	localparam logic CLS_TOGGLE_RST = 1'b0;
	localparam logic CLS_RSTIN_RST  = 1'b0;
	localparam logic CLS_PIN_RST    = 1'b0;

	typedef enum logic [1:0] {
		CLS_SLEEP,
		CLS_NORMAL,
		CLS_FAIL
	} cls_mode_t;

endpackage

// [design/cls_supervisor.sv]
// Operation
// - Any link fault moves the device from Normal into Fail mode.
// - Master inverts toggle bit each frame; an unchanged bit is a fault.
// - No valid frame within 32 ms or 128 ms, by select bit, is a fault.
// - Clock count per chip-select period not a multiple of 16 is a fault.
// - Stuck serial input or lost logic supply shows as a toggle error.
// - A fault sets the link fail flag, reported in the next exchange.
// - The fail flag holds through Fail mode, clears on return to Normal.
// - Limp-home and four direct inputs use a symmetric 200 us filter.
// - Limp-home high past the filter time asserts filtered limp, Fail mode.
// - A direct input high past the filter time drives its channel in Fail mode.
// - Reset input filtered 10 us on falling edge only; rise passes through.
// - Reference clock filtered 2 us both edges; too fast reads as failure.
// - Clock monitoring starts at reset release; below 100 Hz is failure.
// - In Normal, on clock failure outputs follow on/off control; else PWM setting.
// - Clock failure clears after condition ends and quick status is read.
// - External power output driven only in Normal, from channel 6 setting.
// - In Sleep and Fail the external power output is left undriven.
// - In Fail mode each channel follows its filtered direct input.
// - Limp-home input level is readable as a status bit.
`timescale 1ns/100ps
`default_nettype none

module cls_filter
	import cls_pkg::*;
#(
	parameter int   CNT      = 1,
	parameter logic FILT_RISE = 1'b1,
	parameter logic RST_VAL  = 1'b0
)
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic sys_rst,
	// Synchronised input and filtered level.
	input  wire logic din,
	output var  logic dout
);
	logic [CLS_DGL_W-1:0] cnt_q;
	logic                 out_q;
	wire logic            differs = din != out_q;
	wire logic            filt    = din ? FILT_RISE : 1'b1;
	wire logic            done    = cnt_q == CLS_DGL_W'(CNT - 1);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cnt_q <= '0;
			out_q <= RST_VAL;
		end
		else if (differs && (!filt || done))
		begin
			cnt_q <= '0;
			out_q <= din;
		end
		else if (differs)
			cnt_q <= cnt_q + 1'b1;
		else
			cnt_q <= '0;
	end

	assign dout = out_q;
endmodule

module cls_supervisor
	import cls_pkg::*;
#(
	parameter int TWD_SHORT_CYC = CLS_TWD_SHORT_CYC,
	parameter int TWD_LONG_CYC  = CLS_TWD_LONG_CYC,
	parameter int TDGL_IN_CYC   = CLS_TDGL_IN_CYC,
	parameter int CLK_LOW_CYC   = CLS_CLK_LOW_CYC
)
(
	// System clock and reset.
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// Serial link from the master.
	input  wire logic               link_sclk,
	input  wire logic               chip_select_low,
	input  wire logic               link_sdi,
	// Device pins.
	input  wire logic               reset_input_low,
	input  wire logic               limp_home_in,
	input  wire logic [CLS_NCH-1:0] direct_channel_inputs,
	input  wire logic               pwm_ref_clk_in,
	// Controls from the register and PWM logic.
	input  wire logic               link_timeout_select,
	input  wire logic               normal_mode_req,
	input  wire logic               quick_status_read,
	input  wire logic [CLS_NCH-1:0] channel_on_control,
	input  wire logic [CLS_NCH-1:0] pwm_drive,
	input  wire logic               ch6_setting,
	// Status.
	output var  cls_mode_t          mode,
	output var  logic               link_fail_flag,
	output var  logic               limp_home_level,
	output var  logic               limp_home_filtered,
	output var  logic [CLS_NCH-1:0] direct_channel_filtered,
	output var  logic               clk_fail,
	// Power stage controls.
	output var  logic [CLS_NCH-1:0] power_out,
	output var  logic               ext_power_ctrl_out,
	output var  logic               ext_power_ctrl_oe
);
	// Link domain. The link clock stops between frames, so the bit count
	// and last toggle bit stay static until the next frame begins.
	logic [CLS_BITC_W-1:0] bitc_q;
	logic                  active_q;
	logic                  tog_l_q;

	always_ff @(posedge link_sclk or posedge chip_select_low)
	begin
		if (chip_select_low)
			active_q <= 1'b0;
		else
			active_q <= 1'b1;
	end

	wire logic [CLS_BITC_W-1:0] bitc_d = active_q ? bitc_q + 1'b1 : '0;

	// The length flag is a flop of its own: chip-select high clears the
	// active flag at once, so anything derived from it would be gone
	// before the system domain looks at the finished frame.
	logic                  part_l_q;

	always_ff @(posedge link_sclk)
	begin
		bitc_q   <= bitc_d;
		part_l_q <= bitc_d != CLS_BITC_W'(CLS_WORD_BITS - 1);
		if (bitc_d == CLS_TOGGLE_POS)
			tog_l_q <= link_sdi;
	end

	// Crossings into the system domain.
	logic [2:0] cs_s_q;
	logic [1:0] part_s_q;
	logic [1:0] tog_s_q;
	logic [1:0] rst_s_q;
	logic [1:0] limp_s_q;
	logic [1:0] pclk_s_q;
	logic [1:0] din_s_q [CLS_NCH];

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cs_s_q   <= 3'h7;
			part_s_q <= 2'h0;
			tog_s_q  <= 2'h0;
			rst_s_q  <= '0;
			limp_s_q <= '0;
			pclk_s_q <= '0;
		end
		else
		begin
			cs_s_q   <= {cs_s_q[1:0], chip_select_low};
			part_s_q <= {part_s_q[0], part_l_q};
			tog_s_q  <= {tog_s_q[0], tog_l_q};
			rst_s_q  <= {rst_s_q[0], reset_input_low};
			limp_s_q <= {limp_s_q[0], limp_home_in};
			pclk_s_q <= {pclk_s_q[0], pwm_ref_clk_in};
		end
	end

	// Input filters.
	logic               rst_f;
	logic               limp_f;
	logic               pclk_f;
	logic [CLS_NCH-1:0] din_f;

	cls_filter #(.CNT(CLS_TDGL_RST_CYC), .FILT_RISE(1'b0),
		.RST_VAL(CLS_RSTIN_RST)) u_rst_flt (
		.clk(clk), .sys_rst(sys_rst), .din(rst_s_q[1]), .dout(rst_f));
	cls_filter #(.CNT(TDGL_IN_CYC), .RST_VAL(CLS_PIN_RST)) u_limp_flt (
		.clk(clk), .sys_rst(sys_rst), .din(limp_s_q[1]), .dout(limp_f));
	cls_filter #(.CNT(CLS_TDGL_CLK_CYC), .RST_VAL(CLS_PIN_RST)) u_clk_flt (
		.clk(clk), .sys_rst(sys_rst), .din(pclk_s_q[1]), .dout(pclk_f));

	genvar gi;
	generate
		for (gi = 0; gi < CLS_NCH; gi++)
		begin : g_din
			always_ff @(posedge clk)
			begin
				if (sys_rst)
					din_s_q[gi] <= '0;
				else
					din_s_q[gi] <= {din_s_q[gi][0], direct_channel_inputs[gi]};
			end
			cls_filter #(.CNT(TDGL_IN_CYC), .RST_VAL(CLS_PIN_RST)) u_flt (
				.clk(clk), .sys_rst(sys_rst), .din(din_s_q[gi][1]),
				.dout(din_f[gi]));
		end
	endgenerate

	// Frame checks at chip-select release.
	logic               last_tog_q;
	logic [CLS_WD_W-1:0] wd_q;
	wire logic frame_end = cs_s_q[1] && !cs_s_q[2];
	wire logic len_err   = part_s_q[1];
	wire logic tog_err   = tog_s_q[1] == last_tog_q;
	wire logic good_frm  = frame_end && !len_err && !tog_err;
	wire logic [CLS_WD_W-1:0] wd_lim = link_timeout_select
		? CLS_WD_W'(TWD_LONG_CYC - 1) : CLS_WD_W'(TWD_SHORT_CYC - 1);
	wire logic wd_err    = wd_q >= wd_lim;
	wire logic link_err  = (frame_end && (len_err || tog_err)) || wd_err;

	always_ff @(posedge clk)
	begin
		if (sys_rst || !rst_f)
		begin
			last_tog_q <= CLS_TOGGLE_RST;
			wd_q       <= '0;
		end
		else
		begin
			if (good_frm)
				last_tog_q <= tog_s_q[1];
			if (good_frm || wd_err)
				wd_q <= '0;
			else
				wd_q <= wd_q + 1'b1;
		end
	end

	// Mode control and link fail flag.
	cls_mode_t mode_q;
	cls_mode_t mode_d;
	logic      fail_flag_q;
	wire logic to_fail = link_err || limp_f;
	wire logic leave_fail = mode_q == CLS_FAIL && normal_mode_req && !to_fail;

	always_comb
	begin
		mode_d = mode_q;
		unique case (mode_q)
			CLS_SLEEP:  mode_d = to_fail ? CLS_FAIL : CLS_NORMAL;
			CLS_NORMAL: if (to_fail) mode_d = CLS_FAIL;
			CLS_FAIL:   if (leave_fail) mode_d = CLS_NORMAL;
		endcase
		if (!rst_f)
			mode_d = CLS_SLEEP;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			mode_q      <= CLS_SLEEP;
			fail_flag_q <= 1'b0;
		end
		else
		begin
			mode_q <= mode_d;
			if (link_err && rst_f)
				fail_flag_q <= 1'b1;
			else if (leave_fail || !rst_f)
				fail_flag_q <= 1'b0;
		end
	end

	// Reference clock monitor.
	logic [CLS_MON_W-1:0] mon_q;
	logic                 pclk_d_q;
	logic                 cfail_q;
	wire logic pclk_rise = pclk_f && !pclk_d_q;
	wire logic clk_bad   = mon_q >= CLS_MON_W'(CLK_LOW_CYC - 1);

	always_ff @(posedge clk)
	begin
		if (sys_rst || !rst_f)
		begin
			mon_q    <= '0;
			pclk_d_q <= 1'b0;
			cfail_q  <= 1'b0;
		end
		else
		begin
			pclk_d_q <= pclk_f;
			if (pclk_rise)
				mon_q <= '0;
			else if (!clk_bad)
				mon_q <= mon_q + 1'b1;
			if (clk_bad)
				cfail_q <= 1'b1;
			else if (quick_status_read)
				cfail_q <= 1'b0;
		end
	end

	// Output stage.
	logic [CLS_NCH-1:0] pout_q;
	logic               x6_q;
	logic               x6_oe_q;
	logic               limp_lvl_q;
	wire logic [CLS_NCH-1:0] norm_drv = cfail_q ? channel_on_control
		: pwm_drive;
	wire logic [CLS_NCH-1:0] pout_d = mode_q == CLS_FAIL ? din_f
		: (mode_q == CLS_NORMAL ? norm_drv : '0);
	wire logic is_norm = mode_q == CLS_NORMAL;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pout_q     <= '0;
			x6_q       <= 1'b0;
			x6_oe_q    <= 1'b0;
			limp_lvl_q <= 1'b0;
		end
		else
		begin
			pout_q     <= pout_d;
			x6_q       <= is_norm && ch6_setting;
			x6_oe_q    <= is_norm;
			limp_lvl_q <= limp_s_q[1];
		end
	end

	assign mode                    = mode_q;
	assign link_fail_flag          = fail_flag_q;
	assign limp_home_level         = limp_lvl_q;
	assign limp_home_filtered      = limp_f;
	assign direct_channel_filtered = din_f;
	assign clk_fail                = cfail_q;
	assign power_out               = pout_q;
	assign ext_power_ctrl_out      = x6_q;
	assign ext_power_ctrl_oe       = x6_oe_q;
endmodule

`default_nettype wire

// [verif/cls_supervisor_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module cls_supervisor_assertions
	import cls_pkg::*;
(
	// Clock and reset.
	input wire logic               clk,
	input wire logic               sys_rst,
	// Controls and status.
	input wire logic [CLS_NCH-1:0] channel_on_control,
	input wire logic [CLS_NCH-1:0] pwm_drive,
	input wire logic               ch6_setting,
	input wire cls_mode_t          mode,
	input wire logic               link_fail_flag,
	input wire logic               limp_home_filtered,
	input wire logic [CLS_NCH-1:0] direct_channel_filtered,
	input wire logic               clk_fail,
	// Power stage controls.
	input wire logic [CLS_NCH-1:0] power_out,
	input wire logic               ext_power_ctrl_out,
	input wire logic               ext_power_ctrl_oe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	AST_FLAG_SET: assert property ($rose(link_fail_flag) |->
		mode == CLS_FAIL) else $error("fail flag set outside fail mode");
	AST_FLAG_CLR: assert property ($fell(link_fail_flag) |->
		mode != CLS_FAIL) else $error("fail flag cleared in fail mode");
	AST_LIMP: assert property (limp_home_filtered &&
		mode == CLS_NORMAL |=> mode != CLS_NORMAL)
		else $error("filtered limp left mode normal");
	AST_FAIL_PWR: assert property (mode == CLS_FAIL &&
		$past(mode) == CLS_FAIL |-> power_out == $past(direct_channel_filtered))
		else $error("fail mode output not from direct inputs");
	AST_NORM_PWR: assert property (mode == CLS_NORMAL &&
		$past(mode) == CLS_NORMAL && $stable(clk_fail) |-> power_out ==
		($past(clk_fail) ? $past(channel_on_control) : $past(pwm_drive)))
		else $error("normal mode output source wrong");
	AST_OE: assert property (ext_power_ctrl_oe |->
		mode == CLS_NORMAL || $past(mode) == CLS_NORMAL)
		else $error("external output driven outside normal");
	AST_EXT_POWER_CTRL_OUT: assert property (ext_power_ctrl_oe &&
		$past(ext_power_ctrl_oe) |-> ext_power_ctrl_out == $past(ch6_setting))
		else $error("external output not following setting");
	AST_UNDRIVEN: assert property (!ext_power_ctrl_oe |->
		!ext_power_ctrl_out) else $error("undriven output not low");
endmodule
bind cls_supervisor cls_supervisor_assertions u_ast (.*);
`default_nettype wire

// [verif/cls_link_master.sv]
`timescale 1ns/100ps
`default_nettype none
module cls_link_master
(
	// Serial link towards the device.
	output var logic link_sclk,
	output var logic chip_select_low,
	output var logic link_sdi
);
	logic last_q = 1'b0;
	initial
	begin
		link_sclk = 1'b0;
		chip_select_low = 1'b1;
		link_sdi = 1'b0;
	end
	// Sends n clocks; rep repeats the toggle bit to provoke a fault.
	task automatic send(input int n, input logic rep);
		logic tog;
		tog = rep ? last_q : ~last_q;
		last_q = tog;
		chip_select_low = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			#77 link_sdi = (i % 16 == 15) ? tog : i[0];
			#3 link_sclk = 1'b1;
			#80 link_sclk = 1'b0;
		end
		#80 chip_select_low = 1'b1;
		link_sdi = ~link_sdi;
		#400;
	endtask
endmodule
`default_nettype wire

// [verif/cls_supervisor_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module cls_supervisor_tb
	import cls_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic link_sclk, chip_select_low, link_sdi;
	logic reset_input_low = 1'b1, limp_home_in = 1'b0, pwm_ref_clk_in = 1'b0;
	logic link_timeout_select = 1'b1, normal_mode_req = 1'b0;
	logic quick_status_read = 1'b0, ch6_setting = 1'b1;
	logic [CLS_NCH-1:0] direct_channel_inputs = 4'h0;
	logic [CLS_NCH-1:0] channel_on_control = 4'h5, pwm_drive = 4'h3;
	logic [CLS_NCH-1:0] direct_channel_filtered, power_out;
	cls_mode_t mode;
	logic link_fail_flag, limp_home_level, limp_home_filtered, clk_fail;
	logic ext_power_ctrl_out, ext_power_ctrl_oe;
	int err_count = 0, num_checks = 0, ref_half = 300;
	always #5 clk = ~clk;
	always #(ref_half * 10) pwm_ref_clk_in = ~pwm_ref_clk_in;
	cls_supervisor #(.TWD_SHORT_CYC(2000), .TWD_LONG_CYC(8000),
		.TDGL_IN_CYC(20), .CLK_LOW_CYC(1000)) u_dut (.*);
	cls_link_master u_m (.*);
	task automatic check(input string name, input logic [3:0] seen,
		input logic [3:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic frame(input int n, input logic rep);
		u_m.send(n, rep);
		@(negedge clk);
	endtask
	task automatic recover();
		@(negedge clk) normal_mode_req = 1'b1;
		@(negedge clk) normal_mode_req = 1'b0;
		frame(16, 1'b0);
	endtask
	task automatic qread();
		@(negedge clk) quick_status_read = 1'b1;
		@(negedge clk) quick_status_read = 1'b0;
		@(negedge clk);
	endtask
	initial
	begin
		#500_000;
		err_count++;
		print_verdict();
	end
	initial
	begin
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		repeat (10) @(negedge clk);
		check("mode", mode, CLS_NORMAL);
		check("cfail", clk_fail, 1'b0);
		frame(16, 1'b0);
		frame(32, 1'b0);
		check("flag", link_fail_flag, 1'b0);
		check("oe", ext_power_ctrl_oe, 1'b1);
		check("ext_power_ctrl_out", ext_power_ctrl_out, 1'b1);
		check("pwr", power_out, 4'h3);
		frame(16, 1'b1);
		check("mode", mode, CLS_FAIL);
		check("flag", link_fail_flag, 1'b1);
		check("oe", ext_power_ctrl_oe, 1'b0);
		direct_channel_inputs = 4'hA;
		repeat (15) @(negedge clk);
		check("filt", direct_channel_filtered, 4'h0);
		repeat (10) @(negedge clk);
		check("filt", direct_channel_filtered, 4'hA);
		check("pwr", power_out, 4'hA);
		frame(16, 1'b0);
		check("flag", link_fail_flag, 1'b1);
		recover();
		check("flag", link_fail_flag, 1'b0);
		frame(17, 1'b0);
		check("mode", mode, CLS_FAIL);
		// A rejected frame leaves the toggle reference where it was.
		u_m.last_q = 1'b0;
		recover();
		for (int s = 0; s < 2; s++)
		begin
			link_timeout_select = s[0];
			frame(16, 1'b0);
			repeat (s ? 7900 : 1900) @(negedge clk);
			check("mode", mode, CLS_NORMAL);
			repeat (200) @(negedge clk);
			check("mode", mode, CLS_FAIL);
			recover();
		end
		limp_home_in = 1'b1;
		repeat (5) @(negedge clk);
		check("limp", limp_home_level, 1'b1);
		repeat (25) @(negedge clk);
		check("limp_home_filtered", limp_home_filtered, 1'b1);
		check("mode", mode, CLS_FAIL);
		limp_home_in = 1'b0;
		repeat (30) @(negedge clk);
		recover();
		ref_half = 50;
		repeat (1500) @(negedge clk);
		check("cfail", clk_fail, 1'b1);
		check("pwr", power_out, 4'h5);
		qread();
		check("cfail", clk_fail, 1'b1);
		ref_half = 300;
		repeat (1300) @(negedge clk);
		qread();
		check("cfail", clk_fail, 1'b0);
		check("pwr", power_out, 4'h3);
		frame(16, 1'b0);
		reset_input_low = 1'b0;
		repeat (500) @(negedge clk);
		reset_input_low = 1'b1;
		repeat (5) @(negedge clk);
		check("mode", mode, CLS_NORMAL);
		reset_input_low = 1'b0;
		repeat (1100) @(negedge clk);
		check("mode", mode, CLS_SLEEP);
		check("oe", ext_power_ctrl_oe, 1'b0);
		reset_input_low = 1'b1;
		u_m.last_q = 1'b0;
		repeat (6) @(negedge clk);
		check("mode", mode, CLS_NORMAL);
		frame(16, 1'b0);
		check("flag", link_fail_flag, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
